// ### hw/mac_cfg_pkg.sv
// Package of offsets, field positions and reset values for the MAC configuration block
package mac_cfg_pkg;
  // ****************************************
  // Register indices and APB byte addresses
  // ****************************************
  localparam logic [7:0] IDX_CMD = 8'h00;
  localparam logic [7:0] IDX_TX_CFG = 8'h0D;
  localparam logic [7:0] IDX_DATA_CFG = 8'h0E;
  localparam logic [7:0] IDX_STAT = 8'h10;
  localparam logic [11:0] ADDR_CMD = {2'b00, IDX_CMD, 2'b00};
  localparam logic [11:0] ADDR_TX_CFG = {2'b00, IDX_TX_CFG, 2'b00};
  localparam logic [11:0] ADDR_DATA_CFG = {2'b00, IDX_DATA_CFG, 2'b00};
  localparam logic [11:0] ADDR_STAT = {2'b00, IDX_STAT, 2'b00};

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CMD_PS_LSB = 6;
  localparam int DATA_CFG_WORD_BIT = 0;
  localparam int DATA_CFG_LOOP_SEL_BIT = 3;
  localparam int DATA_CFG_FT_LSB = 5;
  localparam int TX_CFG_CRC_BIT = 0;
  localparam int TX_CFG_LB_LSB = 1;
  localparam int TX_CFG_COFF_BIT = 4;

  // ****************************************
  // Writable bits and values after reset
  // ****************************************
  localparam logic [7:0] DATA_CFG_WMASK = 8'h69;
  localparam logic [7:0] TX_CFG_WMASK = 8'h1F;
  localparam logic [7:0] DATA_CFG_RST = 8'h08;
  localparam logic [7:0] TX_CFG_RST = 8'h00;
  localparam logic [1:0] PAGE_RST = 2'h0;
  localparam logic [1:0] PAGE_CFG = 2'h0;

  // ****************************************
  // Loopback codes, thresholds, backoff
  // ****************************************
  typedef enum logic [1:0] {
    LB_NORMAL = 2'b00,
    LB_INTERNAL = 2'b01,
    LB_RSVD2 = 2'b10,
    LB_RSVD3 = 2'b11
  } lb_mode_t;

  localparam logic [4:0] TX_FIFO_BYTES = 5'h10;
  localparam logic [4:0] RX_THR_B0 = 5'h04;
  localparam logic [4:0] RX_THR_B1 = 5'h08;
  localparam logic [4:0] RX_THR_B2 = 5'h10;
  localparam logic [4:0] RX_THR_B3 = 5'h18;
  localparam logic [3:0] BACKOFF_MAX_EXP = 4'hA;
  localparam logic [4:0] COFF_COLLISIONS = 5'h03;
  localparam logic [3:0] COFF_EXP_ADD = 4'h3;
  localparam logic [4:0] COLL_MAX = 5'h10;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
endpackage

// ### hw/backoff_exp.sv
// Backoff exponent for the current collision, with optional collision offset
`timescale 1ns/1ps
`default_nettype none
module backoff_exp
  import mac_cfg_pkg::*;
(
  input wire logic [4:0] coll_num,
  input wire logic offset_en,
  output logic [3:0] exp_out
);
  // ****************************************
  // Exponent selection
  // ****************************************
  logic [3:0] n_clip;
  logic [3:0] n_plus;
  logic use_coff;

  // Collision number clipped to the maximum exponent BACKOFF_MAX_EXP
  assign n_clip = (coll_num > 5'(BACKOFF_MAX_EXP)) ? BACKOFF_MAX_EXP : coll_num[3:0];
  assign n_plus = n_clip + COFF_EXP_ADD;
  assign use_coff = offset_en && (coll_num <= COFF_COLLISIONS);
  // Offset only for the first collisions, then standard
  assign exp_out = !use_coff ? n_clip :
                   (n_plus > BACKOFF_MAX_EXP) ? BACKOFF_MAX_EXP : n_plus;
endmodule // backoff_exp
`default_nettype wire

// ### hw/mac_data_tx_config.sv
// APB-reached data and transmit configuration registers with their datapath controls
`timescale 1ns/1ps
`default_nettype none
module mac_data_tx_config
  import mac_cfg_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [ADDR_W-1:0] dma_addr_in,
  output logic [ADDR_W-1:0] dma_addr,
  output logic dma_word_mode,
  input wire logic [4:0] rx_fifo_level,
  output logic rx_drain_req,
  input wire logic [4:0] tx_fifo_bytes,
  output logic tx_fill_ok,
  output logic crc_append,
  output logic internal_loopback,
  output logic loopback_output_pin,
  input wire logic tx_start,
  input wire logic collision,
  output logic [9:0] backoff_slots,
  output logic backoff_valid,
  output logic [4:0] collision_count
);
  // ****************************************
  // Register state
  // ****************************************
  logic [1:0] page_r;
  logic [7:0] data_cfg_r;
  logic [7:0] tx_cfg_r;
  logic [31:0] prdata_r;
  logic [ADDR_W-1:0] dma_addr_r;
  logic rx_drain_r;
  logic tx_fill_r;
  logic [4:0] coll_r;
  logic [9:0] slots_r;
  logic bo_valid_r;
  logic [15:0] lfsr_r;

  // ****************************************
  // APB decode
  // ****************************************
  logic setup_ph;
  logic access_ph;
  logic wr_en;
  logic cfg_page;
  logic hit_cmd;
  logic hit_tx_cfg;
  logic hit_data_cfg;
  logic hit_stat;
  logic addr_hit;
  logic cmd_we;
  logic tx_cfg_we;
  logic data_cfg_we;

  // Zero-wait slave; errors only on unmapped words
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign wr_en = access_ph && pwrite;
  assign cfg_page = (page_r == PAGE_CFG);
  assign hit_cmd = (paddr == ADDR_CMD);
  assign hit_tx_cfg = (paddr == ADDR_TX_CFG) && cfg_page;
  assign hit_data_cfg = (paddr == ADDR_DATA_CFG) && cfg_page;
  assign hit_stat = (paddr == ADDR_STAT);
  assign addr_hit = hit_cmd || hit_tx_cfg || hit_data_cfg || hit_stat;
  assign cmd_we = wr_en && hit_cmd;
  // Configuration words exist only on the selected page
  assign tx_cfg_we = wr_en && hit_tx_cfg;
  assign data_cfg_we = wr_en && hit_data_cfg;
  assign pready = 1'b1;
  assign pslverr = access_ph && !addr_hit;

  // ****************************************
  // Field views
  // ****************************************
  logic word_mode;
  logic loop_sel_normal;
  logic [1:0] ft_code;
  lb_mode_t lb_code;
  logic crc_inhibit;
  logic coff_en;
  logic [4:0] rx_thr_bytes;
  logic [4:0] rx_thr_units;
  logic [4:0] tx_thr_bytes;

  assign word_mode = data_cfg_r[DATA_CFG_WORD_BIT];
  assign loop_sel_normal = data_cfg_r[DATA_CFG_LOOP_SEL_BIT];
  assign ft_code = data_cfg_r[DATA_CFG_FT_LSB+:2];
  assign lb_code = lb_mode_t'(tx_cfg_r[TX_CFG_LB_LSB+:2]);
  assign crc_inhibit = tx_cfg_r[TX_CFG_CRC_BIT];
  assign coff_en = tx_cfg_r[TX_CFG_COFF_BIT];

  // Byte threshold equals twice the word threshold, so one table serves both
  assign rx_thr_bytes = (ft_code == 2'b00) ? RX_THR_B0 :
                        (ft_code == 2'b01) ? RX_THR_B1 :
                        (ft_code == 2'b10) ? RX_THR_B2 : RX_THR_B3;
  assign rx_thr_units = word_mode ? {1'b0, rx_thr_bytes[4:1]} : rx_thr_bytes;
  // Code 3 would go negative; clamp to zero so transmit never stalls
  assign tx_thr_bytes = (rx_thr_bytes > TX_FIFO_BYTES) ? 5'h00 :
                        5'(TX_FIFO_BYTES - rx_thr_bytes);

  // ****************************************
  // Mode outputs
  // ****************************************
  // Internal loopback needs both select low and code 01
  assign internal_loopback = !loop_sel_normal && (lb_code == LB_INTERNAL);
  // Reserved codes behave as normal; the pin never rises
  assign loopback_output_pin = 1'b0;
  assign crc_append = !crc_inhibit;
  assign dma_word_mode = word_mode;

  // ****************************************
  // Status word read back
  // ****************************************
  logic [31:0] stat_word;
  logic [31:0] rd_mux;

  assign stat_word = {2'h0, crc_append, slots_r, coll_r, tx_thr_bytes, rx_thr_bytes,
                      internal_loopback, word_mode, page_r};
  // Configuration words are write-only and read as zero
  assign rd_mux = hit_cmd ? {24'h0, page_r, 6'h00} :
                  hit_stat ? stat_word : 32'h0;

  // ****************************************
  // Command page register
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      page_r <= PAGE_RST;
    end else if (cmd_we) begin
      page_r <= pwdata[CMD_PS_LSB+:2];
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  // Masks drop reserved bits so they always store as zero; a write still loads every writable bit
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      data_cfg_r <= DATA_CFG_RST;
      tx_cfg_r <= TX_CFG_RST;
    end else begin
      if (data_cfg_we) begin
        data_cfg_r <= pwdata[7:0] & DATA_CFG_WMASK;
      end
      if (tx_cfg_we) begin
        tx_cfg_r <= pwdata[7:0] & TX_CFG_WMASK;
      end
    end
  end

  // ****************************************
  // Read data register
  // ****************************************
  // Loaded in setup so it stands through the access cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata_r <= 32'h0;
    end else if (setup_ph && !pwrite) begin
      prdata_r <= rd_mux;
    end
  end
  assign prdata = prdata_r;

  // ****************************************
  // DMA address and FIFO thresholds
  // ****************************************
  logic [ADDR_W-1:0] word_addr;

  // Word mode: bit 0 forced low, top bit dropped to keep a 32k byte span
  assign word_addr = {1'b0, dma_addr_in[ADDR_W-2:1], 1'b0};
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dma_addr_r <= '0;
      rx_drain_r <= 1'b0;
      tx_fill_r <= 1'b0;
    end else begin
      dma_addr_r <= word_mode ? word_addr : dma_addr_in;
      rx_drain_r <= (rx_fifo_level >= rx_thr_units);
      tx_fill_r <= (tx_fifo_bytes >= tx_thr_bytes);
    end
  end
  assign dma_addr = dma_addr_r;
  assign rx_drain_req = rx_drain_r;
  assign tx_fill_ok = tx_fill_r;

  // ****************************************
  // Backoff draw
  // ****************************************
  logic [4:0] coll_next;
  logic [3:0] bo_exp;
  logic [9:0] bo_mask;
  logic lfsr_fb;

  assign coll_next = (coll_r == COLL_MAX) ? coll_r : coll_r + 5'h01;
  backoff_exp u_exp (
    .coll_num(coll_next),
    .offset_en(coff_en),
    .exp_out(bo_exp)
  );
  // Mask of 2^exp - 1 limits the random draw to the slot range
  assign bo_mask = 10'((11'h001 << bo_exp) - 11'h001);
  assign lfsr_fb = lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10];

  // Free-running generator; new frame restarts the collision count
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lfsr_r <= LFSR_SEED;
      coll_r <= 5'h00;
      slots_r <= 10'h000;
      bo_valid_r <= 1'b0;
    end else begin
      lfsr_r <= {lfsr_r[14:0], lfsr_fb};
      bo_valid_r <= collision && !tx_start;
      if (tx_start) begin
        coll_r <= 5'h00;
      end else if (collision) begin
        coll_r <= coll_next;
        slots_r <= lfsr_r[9:0] & bo_mask;
      end
    end
  end
  assign backoff_slots = slots_r;
  assign backoff_valid = bo_valid_r;
  assign collision_count = coll_r;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Mode and address selection
  chk_word_mode_set: assert property (data_cfg_we && pwdata[0] |=> dma_word_mode)
    else $error("word mode not taken from write");
  chk_word_mode_clr: assert property (data_cfg_we && !pwdata[0] |=> !dma_word_mode)
    else $error("byte mode not taken from write");
  chk_addr_bit_low: assert property (dma_word_mode |=> !dma_addr[0] && !dma_addr[ADDR_W-1])
    else $error("word mode address out of range");
  chk_byte_addr_pass: assert property (!dma_word_mode |=> dma_addr == $past(dma_addr_in))
    else $error("byte mode address altered");
  chk_loop_exit: assert property (data_cfg_we && pwdata[3] |=> !internal_loopback)
    else $error("loopback held with select high");

  // Threshold points; a write in flight would move the level under test
  chk_rx_word_thr: assert property (dma_word_mode && ft_code == 2'b11 && !data_cfg_we
    && rx_fifo_level == 5'h0C |=> rx_drain_req)
    else $error("receive drain missed at 12 words");
  chk_rx_word_low: assert property (dma_word_mode && ft_code == 2'b00 && !data_cfg_we
    && rx_fifo_level == 5'h02 |=> rx_drain_req)
    else $error("receive drain missed at 2 words");
  chk_rx_byte_thr: assert property (!dma_word_mode && ft_code == 2'b01 && !data_cfg_we
    && rx_fifo_level == 5'h07 |=> !rx_drain_req)
    else $error("receive drain early in byte mode");
  chk_tx_thr_gap: assert property (ft_code == 2'b00 && !data_cfg_we
    && tx_fifo_bytes == 5'h0B |=> !tx_fill_ok)
    else $error("transmit threshold too low");
  chk_tx_thr_clamp: assert property (ft_code == 2'b11 && !data_cfg_we |=> tx_fill_ok)
    else $error("transmit stalled at largest code");

  // Transmit configuration fields
  chk_lb_reset: assert property ($fell(sys_rst) |-> lb_code == LB_NORMAL)
    else $error("loopback code not cleared by reset");
  chk_crc_off: assert property (tx_cfg_we && pwdata[0] |=> !crc_append ##1 !crc_append)
    else $error("CRC still appended after inhibit");
  chk_crc_on: assert property (tx_cfg_we && !pwdata[0] |=> crc_append)
    else $error("CRC not appended");
  chk_lb_pin_low: assert property (tx_cfg_we |=> ##[0:3] !loopback_output_pin)
    else $error("loopback pin driven high");
  chk_rsvd_code_norm: assert property (lb_code[1] |-> !internal_loopback)
    else $error("reserved loopback code acted on");

  // Collision counting and backoff draws
  chk_norm_backoff: assert property (backoff_valid && !coff_en && collision_count == 5'h01
    && !$past(tx_cfg_we) |-> backoff_slots <= 10'h001)
    else $error("normal backoff range exceeded");
  chk_coll_clear: assert property (tx_start |=> collision_count == 5'h00)
    else $error("collision count not cleared");
  chk_valid_pulse: assert property (collision && !tx_start |=> backoff_valid)
    else $error("backoff draw not flagged");
  chk_valid_idle: assert property (!collision |=> !backoff_valid)
    else $error("backoff flagged without collision");
  chk_coll_sat: assert property (collision_count == COLL_MAX && collision && !tx_start
    |=> collision_count == COLL_MAX)
    else $error("collision count wrapped");
  chk_collision_offset_enable_backoff: assert property (backoff_valid && coff_en && collision_count == 5'h02
    && !$past(tx_cfg_we) |-> backoff_slots <= 10'h01F)
    else $error("offset backoff range exceeded");
  chk_late_std_draw: assert property (backoff_valid && coff_en && collision_count == 5'h04
    && !$past(tx_cfg_we) |-> backoff_slots <= 10'h00F)
    else $error("offset kept past third collision");

  // Register bus side
  chk_rsvd_ignored: assert property (data_cfg_we |=> (data_cfg_r & ~DATA_CFG_WMASK) == 8'h00)
    else $error("reserved bits stored");
  chk_cfg_read_zero: assert property (setup_ph && !pwrite && (hit_tx_cfg || hit_data_cfg)
    |=> prdata == 32'h00000000)
    else $error("write-only word read back");
  chk_page_write: assert property (cmd_we && pwdata[7:6] == 2'h1 |=> page_r == 2'h1)
    else $error("page select not stored");
  chk_page_refused: assert property (wr_en && paddr == ADDR_DATA_CFG && !cfg_page
    |=> $stable(data_cfg_r))
    else $error("write accepted on wrong page");
  chk_page_err: assert property (access_ph && paddr == ADDR_DATA_CFG && !cfg_page
    |-> pslverr)
    else $error("wrong page not flagged");
  chk_err_idle: assert property (!access_ph |-> !pslverr)
    else $error("error outside access");

  cov_word_drain: cover property (dma_word_mode ##1 rx_drain_req);
  cov_int_loop: cover property (data_cfg_we ##[1:20] internal_loopback);
  cov_collision_offset_enable_draw: cover property (coff_en && backoff_valid && backoff_slots > 10'h007);
  cov_bus_error: cover property (pslverr);
  cov_rsvd_code: cover property (tx_cfg_we && pwdata[2]);
endmodule // mac_data_tx_config
`default_nettype wire

// ### verification/mac_host_model.sv
// APB host model that reaches the configuration block's paged register map
`timescale 1ns/1ps
`default_nettype none
module mac_host_model (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr
);
  int lost = 0;

  // Idle bus from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
  end

  // ****************************************
  // One transfer: setup, access until pready
  // ****************************************
  // Request held until pready is seen; a stuck slave is counted, not waited on forever
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) lost++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // mac_host_model
`default_nettype wire

// ### verification/mac_data_tx_config_tb.sv
// Self-checking testbench for the data and transmit configuration block
`timescale 1ns/1ps
`default_nettype none
module mac_data_tx_config_tb;
  import mac_cfg_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] dma_addr_in = 16'h0000;
  logic [15:0] dma_addr;
  logic dma_word_mode, rx_drain_req, tx_fill_ok, crc_append, internal_loopback;
  logic loopback_output_pin, backoff_valid;
  logic tx_start = 1'b0;
  logic collision = 1'b0;
  logic [4:0] rx_fifo_level = 5'h00;
  logic [4:0] tx_fifo_bytes = 5'h00;
  logic [4:0] collision_count;
  logic [9:0] backoff_slots;
  int miscompares = 0;
  int compares = 0;
  int thr, txt, e;

  // 100 MHz clock
  always #5 clk = ~clk;

  mac_host_model host (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr);
  mac_data_tx_config #(.ADDR_W(16)) uut (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .dma_addr_in, .dma_addr, .dma_word_mode,
    .rx_fifo_level, .rx_drain_req, .tx_fifo_bytes, .tx_fill_ok, .crc_append,
    .internal_loopback, .loopback_output_pin, .tx_start, .collision, .backoff_slots,
    .backoff_valid, .collision_count);

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("Compares %0d, miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Bus access; the 1 ns step lets the write's register update land
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    host.xfer(w, a, d, rd, err);
    #1;
    if (host.lost != 0) begin
      miscompares++;
      results();
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Hang guard
  initial begin
    #500000;
    miscompares++;
    results();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    step(1);
    chk(32'(crc_append), 32'h00000001);
    chk(32'(internal_loopback), 32'h00000000);
    bus(1'b0, ADDR_STAT, 32'h00000000);
    chk(rd & 32'h2000000F, 32'h20000000);
    bus(1'b0, 12'h0FC, 32'h00000000);
    chk(32'(err), 32'h00000001);
    // Wrong page first: the config word must be refused
    bus(1'b1, ADDR_CMD, 32'h00000040);
    bus(1'b1, ADDR_DATA_CFG, 32'h00000001);
    chk(32'(err), 32'h00000001);
    chk(32'(dma_word_mode), 32'h00000000);
    bus(1'b1, ADDR_CMD, 32'h00000000);
    // Every threshold code in both widths, just below and at the level
    for (int m = 0; m < 2; m++) begin
      for (int f = 0; f < 4; f++) begin
        bus(1'b1, ADDR_DATA_CFG, 32'(f * 32 + 8 + m));
        thr = (f == 3) ? 24 : 4 << f;
        txt = (thr >= 16) ? 0 : 16 - thr;
        if (m == 1) thr = thr / 2;
        @(posedge clk);
        dma_addr_in <= 16'hFFFF;
        rx_fifo_level <= 5'(thr - 1);
        tx_fifo_bytes <= 5'(txt - 1);
        step(2);
        chk(32'(dma_word_mode), 32'(m));
        chk(32'(dma_addr), m ? 32'h00007FFE : 32'h0000FFFF);
        chk(32'(rx_drain_req), 32'h00000000);
        chk(32'(tx_fill_ok), 32'(txt == 0));
        @(posedge clk);
        rx_fifo_level <= 5'(thr);
        tx_fifo_bytes <= 5'(txt);
        step(2);
        chk(32'(rx_drain_req), 32'h00000001);
        chk(32'(tx_fill_ok), 32'h00000001);
      end
    end
    // Loopback needs both registers; reserved codes stay normal
    bus(1'b1, ADDR_DATA_CFG, 32'h00000000);
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, ADDR_TX_CFG, 32'(c * 2));
      chk(32'(internal_loopback), 32'(c == 1));
      chk(32'(loopback_output_pin), 32'h00000000);
    end
    bus(1'b1, ADDR_DATA_CFG, 32'h00000008);
    bus(1'b1, ADDR_TX_CFG, 32'h00000002);
    chk(32'(internal_loopback), 32'h00000000);
    bus(1'b1, ADDR_TX_CFG, 32'h00000001);
    chk(32'(crc_append), 32'h00000000);
    // Only reserved bits set, on purpose
    bus(1'b1, ADDR_TX_CFG, 32'h000000E0);
    chk(32'(crc_append), 32'h00000001);
    // Collisions past saturation, offset off then on
    for (int o = 0; o < 2; o++) begin
      bus(1'b1, ADDR_TX_CFG, 32'(o * 16));
      @(posedge clk);
      tx_start <= 1'b1;
      @(posedge clk);
      tx_start <= 1'b0;
      step(1);
      chk(32'(collision_count), 32'h00000000);
      for (int k = 1; k < 18; k++) begin
        @(posedge clk);
        collision <= 1'b1;
        @(posedge clk);
        collision <= 1'b0;
        #1;
        e = (o == 1 && k <= 3) ? k + 3 : k;
        if (e > 10) e = 10;
        chk(32'(backoff_valid), 32'h00000001);
        chk(32'(collision_count), 32'(k > 16 ? 16 : k));
        chk(32'(backoff_slots) >> e, 32'h00000000);
        step(1);
        chk(32'(backoff_valid), 32'h00000000);
      end
    end
    // Second reset mid-run: loopback and inhibit must fall back to power-up values
    bus(1'b1, ADDR_DATA_CFG, 32'h00000001);
    bus(1'b1, ADDR_TX_CFG, 32'h00000003);
    chk(32'(internal_loopback), 32'h00000001);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    step(1);
    chk(32'(internal_loopback), 32'h00000000);
    chk(32'(crc_append), 32'h00000001);
    chk(32'(dma_word_mode), 32'h00000000);
    chk(32'(collision_count), 32'h00000000);
    results();
  end
endmodule // mac_data_tx_config_tb
`default_nettype wire
